// ---- design/iord_pkg.sv ----
// Package: address map, field masks and command codes of the I/O register decoder
package iord_pkg;

  typedef enum logic [2:0] {
    CMD_READ,
    CMD_WRITE,
    CMD_BITSET,
    CMD_BITCLR,
    CMD_SKIPSET,
    CMD_SKIPCLR
  } iord_cmd_t;

  // Address windows
  localparam logic [7:0] BIT_ACC_LAST = 8'h1F;
  localparam logic [7:0] IO_LAST = 8'h3F;
  localparam logic [7:0] DATA_IO_BASE = 8'h20;
  localparam logic [7:0] EXT_FIRST = 8'h60;

  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam int NUM_PORTS = 4;
  localparam int NUM_FLAGS = 5;

  // Short I/O addresses
  localparam logic [5:0] ADDR_PA_PINS = 6'h00;
  localparam logic [5:0] ADDR_PA_DIR = 6'h01;
  localparam logic [5:0] ADDR_PA_OUT = 6'h02;
  localparam logic [5:0] ADDR_PB_PINS = 6'h03;
  localparam logic [5:0] ADDR_PB_DIR = 6'h04;
  localparam logic [5:0] ADDR_PB_OUT = 6'h05;
  localparam logic [5:0] ADDR_PC_PINS = 6'h06;
  localparam logic [5:0] ADDR_PC_DIR = 6'h07;
  localparam logic [5:0] ADDR_PC_OUT = 6'h08;
  localparam logic [5:0] ADDR_PD_PINS = 6'h09;
  localparam logic [5:0] ADDR_PD_DIR = 6'h0A;
  localparam logic [5:0] ADDR_PD_OUT = 6'h0B;
  localparam logic [5:0] ADDR_TMR0_FLAGS = 6'h15;
  localparam logic [5:0] ADDR_TMR1_FLAGS = 6'h16;
  localparam logic [5:0] ADDR_TMR2_FLAGS = 6'h17;
  localparam logic [5:0] ADDR_PCHG_FLAGS = 6'h1B;
  localparam logic [5:0] ADDR_EXT_FLAGS = 6'h1C;
  localparam logic [5:0] ADDR_EXT_MASK = 6'h1D;
  localparam logic [5:0] ADDR_SCRATCH0 = 6'h1E;
  localparam logic [5:0] ADDR_EE_CTRL = 6'h1F;
  localparam logic [5:0] ADDR_EE_DATA = 6'h20;
  localparam logic [5:0] ADDR_EE_ADDR_LO = 6'h21;
  localparam logic [5:0] ADDR_EE_ADDR_HI = 6'h22;
  localparam logic [5:0] ADDR_PRESC_SYNC = 6'h23;
  localparam logic [5:0] ADDR_TMR0_CTRL_A = 6'h24;
  localparam logic [5:0] ADDR_TMR0_CTRL_B = 6'h25;
  localparam logic [5:0] ADDR_TMR0_COUNT = 6'h26;
  localparam logic [5:0] ADDR_TMR0_CMP_A = 6'h27;
  localparam logic [5:0] ADDR_TMR0_CMP_B = 6'h28;
  localparam logic [5:0] ADDR_SCRATCH1 = 6'h2A;
  localparam logic [5:0] ADDR_SCRATCH2 = 6'h2B;
  localparam logic [5:0] ADDR_SPI_CTRL = 6'h2C;

  // Implemented bits of registers with unused positions
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_EXT_MASK = 8'h07;
  localparam logic [7:0] MASK_EE_CTRL = 8'h3F;
  localparam logic [7:0] MASK_EE_ADDR_HI = 8'h0F;
  localparam logic [7:0] MASK_PRESC_SYNC = 8'h83;
  localparam logic [7:0] MASK_TMR0_CTRL_A = 8'hF3;
  localparam logic [7:0] MASK_TMR0_CTRL_B = 8'hCF;

  // Write-one-to-clear flag registers, in order tmr0, tmr1, tmr2, pin change, external
  localparam logic [5:0] FLAG_ADDR [NUM_FLAGS] = '{6'h15, 6'h16, 6'h17, 6'h1B, 6'h1C};
  localparam logic [7:0] FLAG_MASK [NUM_FLAGS] = '{8'h07, 8'h27, 8'h07, 8'h0F, 8'h07};

endpackage : iord_pkg

// ---- design/iord_flag_reg.sv ----
// One write-one-to-clear flag register with set-over-clear priority
module iord_flag_reg #(
  parameter logic [7:0] FLAG_MASK = 8'hFF
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] setEvt,
  input wire logic [7:0] clrMask,
  output logic [7:0] flags
);

  logic [7:0] flags_r;
  logic [7:0] flags_nxt;

  // Clear by one, keep on zero, a new event wins over the clear
  always_comb begin
    flags_nxt = ((flags_r & ~clrMask) | setEvt) & FLAG_MASK;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      flags_r <= iord_pkg::RESET_VAL;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags = flags_r;

  chk_flag_one_clears: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clrMask[0] && !setEvt[0]) |=> !flags_r[0])
    else $error("flag bit 0 not cleared by one");

  chk_flag_zero_keeps: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clrMask == 8'h00 && setEvt == 8'h00) |=> (flags_r == $past(flags_r)))
    else $error("flag changed without set or clear");

  chk_flag_set_wins: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (setEvt[0] && clrMask[0] && FLAG_MASK[0]) |=> flags_r[0])
    else $error("simultaneous set lost to clear");

endmodule : iord_flag_reg

// ---- design/iord_decoder.sv ----
// I/O register space decoder: short and data-space views, bit access, flag clearing
// Function
// - Bit set/clear on short addresses 0x00-0x1F
// - Bit skip tests on the same range
// - Flags clear on written one, zero keeps
// - Bit ops rewrite whole register, only 0x00-0x1F
// - Data address equals short address plus 0x20
// - Extended 0x60-0xFF reachable by data view only
module iord_decoder (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic accValid,
  input wire logic accDataView,
  input wire logic [7:0] accAddr,
  input wire iord_pkg::iord_cmd_t accCmd,
  input wire logic [2:0] accBit,
  input wire logic [7:0] accWrData,
  output logic [7:0] rdData,
  output logic skipTaken,
  output logic accDone,
  output logic accErr,
  input wire logic [7:0] portAPins,
  input wire logic [7:0] portBPins,
  input wire logic [7:0] portCPins,
  input wire logic [7:0] portDPins,
  output logic [7:0] portADir,
  output logic [7:0] portAOut,
  output logic [7:0] portBDir,
  output logic [7:0] portBOut,
  output logic [7:0] portCDir,
  output logic [7:0] portCOut,
  output logic [7:0] portDDir,
  output logic [7:0] portDOut,
  input wire logic [7:0] tmr0FlagSet,
  input wire logic [7:0] tmr1FlagSet,
  input wire logic [7:0] tmr2FlagSet,
  input wire logic [7:0] pinChgFlagSet,
  input wire logic [7:0] extIrqFlagSet,
  output logic [7:0] tmr0Flags,
  output logic [7:0] tmr1Flags,
  output logic [7:0] tmr2Flags,
  output logic [7:0] pinChgFlags,
  output logic [7:0] extIrqFlags,
  output logic [7:0] extIrqMask,
  output logic [7:0] eepromCtrl,
  output logic [7:0] eepromData,
  output logic [7:0] eepromAddrLow,
  output logic [7:0] eepromAddrHigh,
  output logic [7:0] prescalerSync,
  output logic [7:0] tmr0CtrlA,
  output logic [7:0] tmr0CtrlB,
  output logic [7:0] tmr0Count,
  output logic [7:0] tmr0CmpA,
  output logic [7:0] tmr0CmpB,
  output logic [7:0] spiCtrl
);

  // Writable bits of each plain read/write register, zero elsewhere
  function automatic logic [7:0] rwMask(input logic [5:0] a);
    case (a)
      iord_pkg::ADDR_PA_DIR, iord_pkg::ADDR_PA_OUT,
      iord_pkg::ADDR_PB_DIR, iord_pkg::ADDR_PB_OUT,
      iord_pkg::ADDR_PC_DIR, iord_pkg::ADDR_PC_OUT,
      iord_pkg::ADDR_PD_DIR, iord_pkg::ADDR_PD_OUT,
      iord_pkg::ADDR_SCRATCH0, iord_pkg::ADDR_SCRATCH1, iord_pkg::ADDR_SCRATCH2,
      iord_pkg::ADDR_EE_DATA, iord_pkg::ADDR_EE_ADDR_LO,
      iord_pkg::ADDR_TMR0_COUNT, iord_pkg::ADDR_TMR0_CMP_A, iord_pkg::ADDR_TMR0_CMP_B,
      iord_pkg::ADDR_SPI_CTRL: rwMask = iord_pkg::MASK_FULL;
      iord_pkg::ADDR_EXT_MASK: rwMask = iord_pkg::MASK_EXT_MASK;
      iord_pkg::ADDR_EE_CTRL: rwMask = iord_pkg::MASK_EE_CTRL;
      iord_pkg::ADDR_EE_ADDR_HI: rwMask = iord_pkg::MASK_EE_ADDR_HI;
      iord_pkg::ADDR_PRESC_SYNC: rwMask = iord_pkg::MASK_PRESC_SYNC;
      iord_pkg::ADDR_TMR0_CTRL_A: rwMask = iord_pkg::MASK_TMR0_CTRL_A;
      iord_pkg::ADDR_TMR0_CTRL_B: rwMask = iord_pkg::MASK_TMR0_CTRL_B;
      default: rwMask = 8'h00;
    endcase
  endfunction : rwMask

  function automatic logic isBitCmd(input iord_pkg::iord_cmd_t c);
    isBitCmd = (c == iord_pkg::CMD_BITSET) || (c == iord_pkg::CMD_BITCLR) ||
               (c == iord_pkg::CMD_SKIPSET) || (c == iord_pkg::CMD_SKIPCLR);
  endfunction : isBitCmd

  logic [7:0] pinRaw [iord_pkg::NUM_PORTS];
  logic [7:0] pinMeta_r [iord_pkg::NUM_PORTS];
  logic [7:0] pinSync_r [iord_pkg::NUM_PORTS];
  logic [7:0] flagSet [iord_pkg::NUM_FLAGS];
  logic [7:0] flagClr [iord_pkg::NUM_FLAGS];
  logic [7:0] flagVal [iord_pkg::NUM_FLAGS];
  logic [7:0] regs_r [64];
  logic [7:0] dataOffset;
  logic [5:0] shortAddr;
  logic inIoMap;
  logic reqErr;
  logic hit;
  logic wrEn;
  logic [7:0] bitSel;
  logic [7:0] curVal;
  logic [7:0] wrVal;
  logic [7:0] rdData_nxt;
  logic skipTaken_nxt;
  logic [7:0] rdData_r;
  logic skipTaken_r;
  logic accDone_r;
  logic accErr_r;

  assign pinRaw[0] = portAPins;
  assign pinRaw[1] = portBPins;
  assign pinRaw[2] = portCPins;
  assign pinRaw[3] = portDPins;

  // Two-stage synchronisers on the pin inputs
  for (genvar p = 0; p < iord_pkg::NUM_PORTS; p++) begin : gPinSync
    always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
        pinMeta_r[p] <= iord_pkg::RESET_VAL;
        pinSync_r[p] <= iord_pkg::RESET_VAL;
      end else begin
        pinMeta_r[p] <= pinRaw[p];
        pinSync_r[p] <= pinMeta_r[p];
      end
    end
  end

  // Both views land on one short address
  assign dataOffset = accAddr - iord_pkg::DATA_IO_BASE;
  assign shortAddr = accDataView ? dataOffset[5:0] : accAddr[5:0];
  assign inIoMap = accDataView ?
                   (accAddr >= iord_pkg::DATA_IO_BASE && accAddr < iord_pkg::EXT_FIRST) :
                   (accAddr <= iord_pkg::IO_LAST);

  // Short addresses past 0x3F and bit ops outside 0x00-0x1F are refused
  always_comb begin
    reqErr = 1'b0;
    if (accValid) begin
      if (!accDataView && accAddr > iord_pkg::IO_LAST) begin
        reqErr = 1'b1;
      end
      if (accDataView && accAddr < iord_pkg::DATA_IO_BASE) begin
        reqErr = 1'b1;
      end
      if (isBitCmd(accCmd) && (accDataView || accAddr > iord_pkg::BIT_ACC_LAST)) begin
        reqErr = 1'b1;
      end
    end
  end

  assign hit = accValid && !reqErr && inIoMap;
  assign bitSel = 8'h01 << accBit;

  // Read path; extended data addresses and reserved locations give zero
  always_comb begin
    curVal = 8'h00;
    if (inIoMap) begin
      curVal = regs_r[shortAddr];
      case (shortAddr)
        iord_pkg::ADDR_PA_PINS: curVal = pinSync_r[0];
        iord_pkg::ADDR_PB_PINS: curVal = pinSync_r[1];
        iord_pkg::ADDR_PC_PINS: curVal = pinSync_r[2];
        iord_pkg::ADDR_PD_PINS: curVal = pinSync_r[3];
        default: curVal = regs_r[shortAddr];
      endcase
      for (int i = 0; i < iord_pkg::NUM_FLAGS; i++) begin
        if (shortAddr == iord_pkg::FLAG_ADDR[i]) begin
          curVal = flagVal[i];
        end
      end
    end
  end

  // Bit ops rewrite the whole value that was read
  always_comb begin
    wrEn = 1'b0;
    wrVal = accWrData;
    case (accCmd)
      iord_pkg::CMD_WRITE: begin
        wrEn = hit;
      end
      iord_pkg::CMD_BITSET: begin
        wrEn = hit;
        wrVal = curVal | bitSel;
      end
      iord_pkg::CMD_BITCLR: begin
        wrEn = hit;
        wrVal = curVal & ~bitSel;
      end
      default: begin
        wrEn = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < 64; i++) begin
        regs_r[i] <= iord_pkg::RESET_VAL;
      end
    end else if (wrEn) begin
      regs_r[shortAddr] <= wrVal & rwMask(shortAddr);
    end
  end

  assign flagSet[0] = tmr0FlagSet;
  assign flagSet[1] = tmr1FlagSet;
  assign flagSet[2] = tmr2FlagSet;
  assign flagSet[3] = pinChgFlagSet;
  assign flagSet[4] = extIrqFlagSet;

  for (genvar f = 0; f < iord_pkg::NUM_FLAGS; f++) begin : gFlags
    // A written one clears; bit ops write back ones of flags already set
    assign flagClr[f] = (wrEn && shortAddr == iord_pkg::FLAG_ADDR[f]) ? wrVal : 8'h00;
    iord_flag_reg #(
      .FLAG_MASK(iord_pkg::FLAG_MASK[f])
    ) uFlag (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .setEvt(flagSet[f]),
      .clrMask(flagClr[f]),
      .flags(flagVal[f])
    );
  end

  assign tmr0Flags = flagVal[0];
  assign tmr1Flags = flagVal[1];
  assign tmr2Flags = flagVal[2];
  assign pinChgFlags = flagVal[3];
  assign extIrqFlags = flagVal[4];

  // Answer path, one cycle after the request
  always_comb begin
    rdData_nxt = 8'h00;
    skipTaken_nxt = 1'b0;
    if (hit && accCmd == iord_pkg::CMD_READ) begin
      rdData_nxt = curVal;
    end
    if (hit && accCmd == iord_pkg::CMD_SKIPSET) begin
      skipTaken_nxt = curVal[accBit];
    end
    if (hit && accCmd == iord_pkg::CMD_SKIPCLR) begin
      skipTaken_nxt = !curVal[accBit];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rdData_r <= iord_pkg::RESET_VAL;
      skipTaken_r <= 1'b0;
      accDone_r <= 1'b0;
      accErr_r <= 1'b0;
    end else begin
      rdData_r <= rdData_nxt;
      skipTaken_r <= skipTaken_nxt;
      accDone_r <= accValid;
      accErr_r <= reqErr;
    end
  end

  assign rdData = rdData_r;
  assign skipTaken = skipTaken_r;
  assign accDone = accDone_r;
  assign accErr = accErr_r;

  assign portADir = regs_r[iord_pkg::ADDR_PA_DIR];
  assign portAOut = regs_r[iord_pkg::ADDR_PA_OUT];
  assign portBDir = regs_r[iord_pkg::ADDR_PB_DIR];
  assign portBOut = regs_r[iord_pkg::ADDR_PB_OUT];
  assign portCDir = regs_r[iord_pkg::ADDR_PC_DIR];
  assign portCOut = regs_r[iord_pkg::ADDR_PC_OUT];
  assign portDDir = regs_r[iord_pkg::ADDR_PD_DIR];
  assign portDOut = regs_r[iord_pkg::ADDR_PD_OUT];
  assign extIrqMask = regs_r[iord_pkg::ADDR_EXT_MASK];
  assign eepromCtrl = regs_r[iord_pkg::ADDR_EE_CTRL];
  assign eepromData = regs_r[iord_pkg::ADDR_EE_DATA];
  assign eepromAddrLow = regs_r[iord_pkg::ADDR_EE_ADDR_LO];
  assign eepromAddrHigh = regs_r[iord_pkg::ADDR_EE_ADDR_HI];
  assign prescalerSync = regs_r[iord_pkg::ADDR_PRESC_SYNC];
  assign tmr0CtrlA = regs_r[iord_pkg::ADDR_TMR0_CTRL_A];
  assign tmr0CtrlB = regs_r[iord_pkg::ADDR_TMR0_CTRL_B];
  assign tmr0Count = regs_r[iord_pkg::ADDR_TMR0_COUNT];
  assign tmr0CmpA = regs_r[iord_pkg::ADDR_TMR0_CMP_A];
  assign tmr0CmpB = regs_r[iord_pkg::ADDR_TMR0_CMP_B];
  assign spiCtrl = regs_r[iord_pkg::ADDR_SPI_CTRL];

  default clocking cbMain @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  sequence sBitSetPortA;
    accValid && !accDataView && accAddr == 8'h02 && accCmd == iord_pkg::CMD_BITSET;
  endsequence

  sequence sDataWritePortA;
    accValid && accDataView && accAddr == 8'h22 && accCmd == iord_pkg::CMD_WRITE;
  endsequence

  chk_bit_set_applies: assert property (
    sBitSetPortA |=> portAOut[$past(accBit)] && accDone && !accErr)
    else $error("bit set did not reach port A output");

  chk_bit_clr_applies: assert property (
    (accValid && !accDataView && accAddr == 8'h0B && accCmd == iord_pkg::CMD_BITCLR)
    |=> !portDOut[$past(accBit)] && !accErr)
    else $error("bit clear did not reach port D output");

  chk_skip_test_value: assert property (
    (accValid && !accDataView && accAddr == 8'h1E && accCmd == iord_pkg::CMD_SKIPCLR)
    |=> skipTaken == !$past(regs_r[30][accBit]))
    else $error("skip test gave wrong bit value");

  chk_flag_rmw_clears: assert property (
    (accValid && !accDataView && accAddr == 8'h15 && accCmd == iord_pkg::CMD_BITCLR &&
     tmr0Flags[1] && !tmr0FlagSet[1] && accBit != 3'h1) |=> !tmr0Flags[1])
    else $error("bit op did not clear other set flag");

  chk_bit_range_refused: assert property (
    (accValid && isBitCmd(accCmd) && (accDataView || accAddr > 8'h1F))
    |=> accErr && $stable(spiCtrl) && !skipTaken)
    else $error("bit op outside low range accepted");

  chk_data_view_alias: assert property (
    sDataWritePortA |=> portAOut == $past(accWrData) && !accErr)
    else $error("data view write missed port A output");

  chk_ext_short_refused: assert property (
    (accValid && !accDataView && accAddr >= 8'h60) |=> accErr && rdData == 8'h00)
    else $error("short address above 0x3F accepted");

  chk_reserved_reads_zero: assert property (
    (accValid && accCmd == iord_pkg::CMD_READ &&
     ((accDataView && accAddr >= 8'h60) || (!accDataView && accAddr == 8'h29)))
    |=> rdData == 8'h00 && !accErr)
    else $error("reserved location read non-zero");

endmodule : iord_decoder

// ---- test/iord_core_model.sv ----
// Core-side model issuing short-view and data-view register accesses
module iord_core_model (
  input wire logic sys_clk,
  output logic accValid,
  output logic accDataView,
  output logic [7:0] accAddr,
  output iord_pkg::iord_cmd_t accCmd,
  output logic [2:0] accBit,
  output logic [7:0] accWrData,
  input wire logic [7:0] rdData,
  input wire logic skipTaken,
  input wire logic accDone,
  input wire logic accErr
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    accValid = 1'b0;
    accDataView = 1'b0;
    accAddr = 8'h00;
    accCmd = iord_pkg::CMD_READ;
    accBit = 3'h0;
    accWrData = 8'h00;
  end

  // One access: present after a falling edge, taken at the rising edge, answer one cycle later
  task automatic access(input logic view, input logic [7:0] addr, input iord_pkg::iord_cmd_t cmd,
                        input logic [2:0] bitIdx, input logic [7:0] wdata, output logic [7:0] rd,
                        output logic skip, output logic err, output logic done);
    @(negedge sys_clk);
    accValid = 1'b1;
    accDataView = view;
    accAddr = addr;
    accCmd = cmd;
    accBit = bitIdx;
    accWrData = wdata;
    @(negedge sys_clk);
    accValid = 1'b0;
    rd = rdData;
    skip = skipTaken;
    err = accErr;
    done = accDone;
    // Released fields no longer hold the last value
    accAddr = ~addr;
    accWrData = ~wdata;
    accBit = ~bitIdx;
  endtask : access
endmodule : iord_core_model

// ---- test/testbench.sv ----
// Self-checking bench of the I/O register space decoder
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic accValid, accDataView, skipTaken, accDone, accErr;
  logic [7:0] accAddr, accWrData, rdData;
  // Register outputs in address order, flag outputs in flag order
  wire [7:0] ro [20];
  wire [7:0] fl [5];
  iord_pkg::iord_cmd_t accCmd;
  logic [2:0] accBit;
  logic [7:0] pins [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] fset [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] rdv;
  logic skv, erv, dnv;
  int mismatches = 0;
  int n_tests = 0;

  always #50 sys_clk = ~sys_clk;

  iord_core_model core_u (.sys_clk(sys_clk), .accValid(accValid), .accDataView(accDataView),
    .accAddr(accAddr), .accCmd(accCmd), .accBit(accBit), .accWrData(accWrData),
    .rdData(rdData), .skipTaken(skipTaken), .accDone(accDone), .accErr(accErr));

  iord_decoder dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .accValid(accValid),
    .accDataView(accDataView), .accAddr(accAddr), .accCmd(accCmd), .accBit(accBit),
    .accWrData(accWrData), .rdData(rdData), .skipTaken(skipTaken), .accDone(accDone),
    .accErr(accErr), .portAPins(pins[0]), .portBPins(pins[1]), .portCPins(pins[2]),
    .portDPins(pins[3]), .portADir(ro[0]), .portAOut(ro[1]), .portBDir(ro[2]),
    .portBOut(ro[3]), .portCDir(ro[4]), .portCOut(ro[5]), .portDDir(ro[6]),
    .portDOut(ro[7]), .tmr0FlagSet(fset[0]),
    .tmr1FlagSet(fset[1]), .tmr2FlagSet(fset[2]), .pinChgFlagSet(fset[3]),
    .extIrqFlagSet(fset[4]), .tmr0Flags(fl[0]), .tmr1Flags(fl[1]), .tmr2Flags(fl[2]),
    .pinChgFlags(fl[3]), .extIrqFlags(fl[4]), .extIrqMask(ro[8]), .eepromCtrl(ro[9]),
    .eepromData(ro[10]), .eepromAddrLow(ro[11]), .eepromAddrHigh(ro[12]),
    .prescalerSync(ro[13]), .tmr0CtrlA(ro[14]), .tmr0CtrlB(ro[15]), .tmr0Count(ro[16]),
    .tmr0CmpA(ro[17]), .tmr0CmpB(ro[18]), .spiCtrl(ro[19]));

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Access that must be answered and whose refusal flag must match
  task automatic acc(input logic v, input logic [7:0] a, input iord_pkg::iord_cmd_t c,
                     input logic [2:0] b, input logic [7:0] w, input logic expErr);
    core_u.access(v, a, c, b, w, rdv, skv, erv, dnv);
    chk("accDone", 8'h01, {7'h00, dnv});
    chk("accErr", {7'h00, expErr}, {7'h00, erv});
  endtask : acc

  task automatic t_regs();
    localparam logic [7:0] TA [10] = '{8'h1E, 8'h1D, 8'h1F, 8'h22, 8'h23, 8'h24, 8'h25, 8'h2C,
                                       8'h0C, 8'h29};
    localparam logic [7:0] TM [10] = '{8'hFF, 8'h07, 8'h3F, 8'h0F, 8'h83, 8'hF3, 8'hCF, 8'hFF,
                                       8'h00, 8'h00};
    for (int i = 0; i < 10; i++) begin
      acc(1'b0, TA[i], iord_pkg::CMD_WRITE, 3'h0, 8'hFF, 1'b0);
      acc(1'b1, TA[i] + 8'h20, iord_pkg::CMD_READ, 3'h0, 8'h00, 1'b0);
      chk("data view read", TM[i], rdv);
    end
    chk("extIrqMask", 8'h07, ro[8]);
    acc(1'b1, 8'h3E, iord_pkg::CMD_WRITE, 3'h0, 8'hA5, 1'b0);
    acc(1'b0, 8'h1E, iord_pkg::CMD_READ, 3'h0, 8'h00, 1'b0);
    chk("short view read", 8'hA5, rdv);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_bitops();
    acc(1'b0, 8'h05, iord_pkg::CMD_WRITE, 3'h0, 8'h81, 1'b0);
    acc(1'b0, 8'h05, iord_pkg::CMD_BITSET, 3'h3, 8'h00, 1'b0);
    chk("portBOut set", 8'h89, ro[3]);
    acc(1'b0, 8'h05, iord_pkg::CMD_BITCLR, 3'h7, 8'h00, 1'b0);
    chk("portBOut clear", 8'h09, ro[3]);
    acc(1'b0, 8'h05, iord_pkg::CMD_SKIPSET, 3'h3, 8'h00, 1'b0);
    chk("skip set taken", 8'h01, {7'h00, skv});
    acc(1'b0, 8'h05, iord_pkg::CMD_SKIPSET, 3'h1, 8'h00, 1'b0);
    chk("skip set not taken", 8'h00, {7'h00, skv});
    acc(1'b0, 8'h05, iord_pkg::CMD_SKIPCLR, 3'h1, 8'h00, 1'b0);
    chk("skip clear taken", 8'h01, {7'h00, skv});
    acc(1'b0, 8'h20, iord_pkg::CMD_BITSET, 3'h0, 8'h00, 1'b1);
    acc(1'b1, 8'h25, iord_pkg::CMD_BITCLR, 3'h0, 8'h00, 1'b1);
    acc(1'b0, 8'h1F, iord_pkg::CMD_SKIPCLR, 3'h0, 8'h00, 1'b0);
    chk("skip clear not taken", 8'h00, {7'h00, skv});
    acc(1'b0, 8'h1E, iord_pkg::CMD_SKIPCLR, 3'h1, 8'h00, 1'b0);
    chk("skip clear scratch", 8'h01, {7'h00, skv});
    acc(1'b0, 8'h20, iord_pkg::CMD_READ, 3'h0, 8'h00, 1'b0);
    chk("refused bit op", 8'h00, rdv);
    chk("portBOut kept", 8'h09, ro[3]);
    $display("t_bitops done");
  endtask : t_bitops

  task automatic t_flags();
    @(negedge sys_clk);
    for (int i = 0; i < 5; i++) fset[i] = 8'hFF;
    @(negedge sys_clk);
    for (int i = 0; i < 5; i++) fset[i] = 8'h00;
    for (int i = 0; i < 5; i++) begin
      chk("flag output", iord_pkg::FLAG_MASK[i], fl[i]);
      acc(1'b0, {2'b00, iord_pkg::FLAG_ADDR[i]}, iord_pkg::CMD_READ, 3'h0, 8'h00, 1'b0);
      chk("flag read", iord_pkg::FLAG_MASK[i], rdv);
    end
    acc(1'b0, 8'h15, iord_pkg::CMD_WRITE, 3'h0, 8'h00, 1'b0);
    chk("flags zero write", 8'h07, fl[0]);
    acc(1'b0, 8'h15, iord_pkg::CMD_WRITE, 3'h0, 8'h02, 1'b0);
    chk("flags one write", 8'h05, fl[0]);
    acc(1'b0, 8'h15, iord_pkg::CMD_BITSET, 3'h1, 8'h00, 1'b0);
    chk("flags bit set", 8'h00, fl[0]);
    // Event and written one in the same cycle
    fset[0] = 8'h01;
    acc(1'b0, 8'h15, iord_pkg::CMD_WRITE, 3'h0, 8'h01, 1'b0);
    fset[0] = 8'h00;
    chk("flag set over clear", 8'h01, fl[0]);
    @(negedge sys_clk);
    fset[0] = 8'h02;
    @(negedge sys_clk);
    fset[0] = 8'h00;
    // Clearing bit 0 writes back the set bit 1 as one
    acc(1'b0, 8'h15, iord_pkg::CMD_BITCLR, 3'h0, 8'h00, 1'b0);
    chk("flags bit clear", 8'h01, fl[0]);
    $display("t_flags done");
  endtask : t_flags

  task automatic t_views();
    acc(1'b0, 8'h60, iord_pkg::CMD_READ, 3'h0, 8'h00, 1'b1);
    acc(1'b0, 8'h40, iord_pkg::CMD_WRITE, 3'h0, 8'h11, 1'b1);
    acc(1'b1, 8'h10, iord_pkg::CMD_READ, 3'h0, 8'h00, 1'b1);
    acc(1'b1, 8'h60, iord_pkg::CMD_WRITE, 3'h0, 8'h33, 1'b0);
    acc(1'b1, 8'h60, iord_pkg::CMD_READ, 3'h0, 8'h00, 1'b0);
    chk("extended read", 8'h00, rdv);
    acc(1'b0, 8'h3F, iord_pkg::CMD_READ, 3'h0, 8'h00, 1'b0);
    $display("t_views done");
  endtask : t_views

  task automatic t_pins();
    @(negedge sys_clk);
    pins = '{8'h5A, 8'hC3, 8'h96, 8'h1E};
    repeat (3) @(negedge sys_clk);
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, 8'(3 * i), iord_pkg::CMD_WRITE, 3'h0, 8'h00, 1'b0);
      acc(1'b1, 8'(3 * i + 32), iord_pkg::CMD_READ, 3'h0, 8'h00, 1'b0);
      chk("pins read", pins[i], rdv);
    end
    $display("t_pins done");
  endtask : t_pins

  task automatic t_outs();
    localparam logic [7:0] OA [20] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h07, 8'h08, 8'h0A, 8'h0B,
                                       8'h1D, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25,
                                       8'h26, 8'h27, 8'h28, 8'h2C};
    localparam logic [7:0] OM [20] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
                                       8'h07, 8'h3F, 8'hFF, 8'hFF, 8'h0F, 8'h83, 8'hF3, 8'hCF,
                                       8'hFF, 8'hFF, 8'hFF, 8'hFF};
    logic [7:0] wv;
    // Odd entries through the data view; all written before any is checked
    for (int k = 0; k < 20; k++) begin
      wv = 8'hC3 ^ 8'(k * 17);
      acc(k[0], OA[k] + (k[0] ? 8'h20 : 8'h00), iord_pkg::CMD_WRITE, 3'h0, wv, 1'b0);
    end
    for (int k = 0; k < 20; k++) begin
      wv = 8'hC3 ^ 8'(k * 17);
      chk("register output", wv & OM[k], ro[k]);
    end
    acc(1'b0, 8'h02, iord_pkg::CMD_BITSET, 3'h2, 8'h00, 1'b0);
    chk("portAOut bit set", 8'hD6, ro[1]);
    acc(1'b0, 8'h0B, iord_pkg::CMD_BITCLR, 3'h7, 8'h00, 1'b0);
    chk("portDOut bit clear", 8'h34, ro[7]);
    $display("t_outs done");
  endtask : t_outs

  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (6) @(negedge sys_clk);
    rst_b = 1'b1;
    @(negedge sys_clk);
    t_regs();
    t_bitops();
    t_flags();
    t_views();
    t_pins();
    t_outs();
    complete_run();
  end

  // About 80 accesses of two cycles each; far more is a hang
  initial begin
    #1000000;
    mismatches++;
    complete_run();
  end
endmodule : testbench
